/* rtl/isd_split_desc.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module isd_split_desc
  import isd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic uframe_tick,
  input wire logic [2:0] uframe_index,
  input wire logic [4:0] bus_frame,
  output logic split_issue,
  output logic split_is_complete,
  output logic [2:0] split_uframe,
  input wire logic result_valid,
  input wire logic [7:0] result_bytes,
  input wire logic [2:0] result_code
);
  ////////////////////////////////////////////////////////////////////////////////
  // bus write side state
  logic aw_held, w_held, bvalid;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held, next_w_held, next_bvalid;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic [1:0] bresp, next_bresp;
  logic wr_fire, wr_hit;
  // bus read side state
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  // descriptor and scheduler state
  logic run, is_in, done;
  logic [4:0] desc_frame;
  logic [7:0] ss_mask, cs_mask;
  logic next_run, next_is_in, next_done;
  logic [4:0] next_desc_frame;
  logic [7:0] next_ss_mask, next_cs_mask;
  isd_state_e state, next_state;
  logic [2:0] pend_uf, next_pend_uf;
  logic pend_cs, next_pend_cs;
  logic issue, issue_cs, next_issue, next_issue_cs;
  logic [2:0] issue_uf, next_issue_uf;
  logic start_pulse, res_take;
  logic [7:0] clr_bits, eff_cs;
  logic [7:0] cnt [ISD_UFRAMES];
  logic [2:0] code [ISD_UFRAMES];
  logic [2:0] masked_code;

  ////////////////////////////////////////////////////////////////////////////////
  // result slots, one per microframe
  isd_slot_if slot_bus [ISD_UFRAMES] ();
  for (genvar g = 0; g < ISD_UFRAMES; g++)
  begin : g_slot
    assign slot_bus[g].clr = start_pulse;
    assign slot_bus[g].wr = res_take && (pend_uf == 3'(g));
    assign slot_bus[g].wr_count = is_in; // only IN brings bytes back
    assign slot_bus[g].count_in = result_bytes;
    assign slot_bus[g].code_in = masked_code;
    assign cnt[g] = slot_bus[g].count;
    assign code[g] = slot_bus[g].code;
    isd_uframe_slot u_slot (
      .aclk(aclk),
      .aresetn(aresetn),
      .sb(slot_bus[g])
    );
  end

  // babble kept only for IN, underrun only for OUT
  assign masked_code = result_code & (is_in ? ISD_CODE_IN_KEEP : ISD_CODE_OUT_KEEP);
  assign eff_cs = is_in ? cs_mask : ISD_MASK_RST;
  assign res_take = (state == ISD_WAIT_RESULT) && result_valid;
  assign clr_bits = res_take ? (8'h01 << pend_uf) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_hit = (aw_addr == ISD_OFS_CTRL) || (aw_addr == ISD_OFS_STAT) ||
    (aw_addr == ISD_OFS_RESULT_WORD) || (aw_addr == ISD_OFS_COUNT_LO) ||
    (aw_addr == ISD_OFS_COUNT_MID) || (aw_addr == ISD_OFS_COUNT_HI);
  assign start_pulse = wr_fire && (aw_addr == ISD_OFS_CTRL) && w_strb[0] &&
    w_data[ISD_CTRL_RUN];

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? ISD_RESP_OKAY : ISD_RESP_SLVERR;
    end
    else if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= ISD_RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  ////////////////////////////////////////////////////////////////////////////////
  // axi read channel: one read in flight, data registered
  assign s_axi_arready = !rvalid;

  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = ISD_RESP_OKAY;
      next_rdata = 32'h00000000;
      case ({s_axi_araddr[7:2], 2'b00})
        ISD_OFS_CTRL: next_rdata = {25'h0, desc_frame, is_in, run};
        ISD_OFS_STAT: next_rdata = {30'h0, done, state != ISD_IDLE};
        // result codes above the start-split mask
        ISD_OFS_RESULT_WORD: next_rdata = {code[7], code[6], code[5], code[4],
          code[3], code[2], code[1], code[0], ss_mask};
        ISD_OFS_COUNT_LO: next_rdata = {cnt[2], cnt[1], cnt[0], cs_mask};
        ISD_OFS_COUNT_MID: next_rdata = {cnt[6], cnt[5], cnt[4], cnt[3]};
        ISD_OFS_COUNT_HI: next_rdata = {24'h0, cnt[7]};
        default: next_rresp = ISD_RESP_SLVERR;
      endcase
    end
    else if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= ISD_RESP_OKAY;
    end
    else
    begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  ////////////////////////////////////////////////////////////////////////////////
  // descriptor control, masks and split scheduler
  always_comb
  begin
    next_run = run;
    next_is_in = is_in;
    next_desc_frame = desc_frame;
    next_done = done;
    // hardware clears processed bits; a software write in the same cycle wins
    next_ss_mask = ss_mask & ~(pend_cs ? 8'h00 : clr_bits);
    next_cs_mask = cs_mask & ~(pend_cs ? clr_bits : 8'h00);
    next_state = state;
    next_pend_uf = pend_uf;
    next_pend_cs = pend_cs;
    next_issue = 1'b0;
    next_issue_cs = issue_cs;
    next_issue_uf = issue_uf;
    case (state)
      ISD_IDLE:
        if (run)
          next_state = ISD_WAIT_TICK;
      ISD_WAIT_TICK:
        // both split kinds are only taken in the descriptor's own frame
        if (uframe_tick && (bus_frame == desc_frame))
        begin
          if (ss_mask[uframe_index])
          begin
            next_issue = 1'b1;
            next_issue_cs = 1'b0;
            next_pend_cs = 1'b0;
            next_issue_uf = uframe_index;
            next_pend_uf = uframe_index;
            next_state = ISD_WAIT_RESULT;
          end
          else if (eff_cs[uframe_index])
          begin
            next_issue = 1'b1;
            next_issue_cs = 1'b1;
            next_pend_cs = 1'b1;
            next_issue_uf = uframe_index;
            next_pend_uf = uframe_index;
            next_state = ISD_WAIT_RESULT;
          end
        end
      ISD_WAIT_RESULT:
        if (result_valid)
          next_state = ISD_CHECK;
      ISD_CHECK:
        // slots and masks settled last cycle, so completion follows them
        if ((ss_mask | eff_cs) == ISD_MASK_RST)
        begin
          next_done = 1'b1;
          next_run = 1'b0;
          next_state = ISD_IDLE;
        end
        else
          next_state = ISD_WAIT_TICK;
      default:
        next_state = ISD_IDLE;
    endcase
    if (wr_fire && w_strb[0])
    begin
      case (aw_addr)
        ISD_OFS_CTRL:
        begin
          next_run = w_data[ISD_CTRL_RUN];
          next_is_in = w_data[ISD_CTRL_IS_IN];
          next_desc_frame = w_data[ISD_CTRL_FRAME_LSB +: ISD_FRAME_W];
        end
        // done is write-one-to-clear; a completion in the same cycle wins
        ISD_OFS_STAT:
          if (w_data[ISD_STAT_DONE] && !(state == ISD_CHECK && next_done))
            next_done = 1'b0;
        ISD_OFS_RESULT_WORD: next_ss_mask = w_data[7:0];
        ISD_OFS_COUNT_LO: next_cs_mask = w_data[7:0];
        default: next_done = next_done;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run <= 1'b0;
      is_in <= 1'b0;
      desc_frame <= 5'h00;
      done <= 1'b0;
      ss_mask <= ISD_MASK_RST;
      cs_mask <= ISD_MASK_RST;
      state <= ISD_IDLE;
      pend_uf <= 3'h0;
      pend_cs <= 1'b0;
      issue <= 1'b0;
      issue_cs <= 1'b0;
      issue_uf <= 3'h0;
    end
    else
    begin
      run <= next_run;
      is_in <= next_is_in;
      desc_frame <= next_desc_frame;
      done <= next_done;
      ss_mask <= next_ss_mask;
      cs_mask <= next_cs_mask;
      state <= next_state;
      pend_uf <= next_pend_uf;
      pend_cs <= next_pend_cs;
      issue <= next_issue;
      issue_cs <= next_issue_cs;
      issue_uf <= next_issue_uf;
    end
  end

  assign split_issue = issue;
  assign split_is_complete = issue_cs;
  assign split_uframe = issue_uf;
endmodule : isd_split_desc
`default_nettype wire

/* rtl/isd_pkg.sv */
package isd_pkg;
  // register byte offsets
  localparam logic [7:0] ISD_OFS_CTRL = 8'h00;
  localparam logic [7:0] ISD_OFS_STAT = 8'h04;
  localparam logic [7:0] ISD_OFS_RESULT_WORD = 8'h08;
  localparam logic [7:0] ISD_OFS_COUNT_LO = 8'h0C;
  localparam logic [7:0] ISD_OFS_COUNT_MID = 8'h10;
  localparam logic [7:0] ISD_OFS_COUNT_HI = 8'h14;
  // control fields
  localparam int ISD_CTRL_RUN = 0;
  localparam int ISD_CTRL_IS_IN = 1;
  localparam int ISD_CTRL_FRAME_LSB = 2;
  localparam int ISD_FRAME_W = 5;
  // status fields
  localparam int ISD_STAT_BUSY = 0;
  localparam int ISD_STAT_DONE = 1;
  // descriptor geometry
  localparam int ISD_UFRAMES = 8;
  localparam int ISD_COUNT_W = 8;
  localparam int ISD_CODE_W = 3;
  localparam int ISD_CODE_LSB = 8;
  // result code bits
  localparam int ISD_CODE_XACT_ERR = 0;
  localparam int ISD_CODE_BABBLE = 1;
  localparam int ISD_CODE_UNDERRUN = 2;
  localparam logic [2:0] ISD_CODE_IN_KEEP = 3'h3;
  localparam logic [2:0] ISD_CODE_OUT_KEEP = 3'h5;
  // reset values
  localparam logic [7:0] ISD_MASK_RST = 8'h00;
  localparam logic [7:0] ISD_COUNT_RST = 8'h00;
  localparam logic [2:0] ISD_CODE_RST = 3'h0;
  // axi responses
  localparam logic [1:0] ISD_RESP_OKAY = 2'h0;
  localparam logic [1:0] ISD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ISD_IDLE, ISD_WAIT_TICK, ISD_WAIT_RESULT, ISD_CHECK} isd_state_e;
endpackage : isd_pkg

/* rtl/isd_slot_if.sv */
`timescale 1ns/1ps
`default_nettype none
// one microframe result slot: control side writes, slot side holds fields
interface isd_slot_if;
  logic clr;
  logic wr;
  logic wr_count;
  logic [7:0] count_in;
  logic [2:0] code_in;
  logic [7:0] count;
  logic [2:0] code;
  modport ctl (output clr, output wr, output wr_count, output count_in, output code_in,
    input count, input code);
  modport slot (input clr, input wr, input wr_count, input count_in, input code_in,
    output count, output code);
endinterface : isd_slot_if
`default_nettype wire

/* rtl/isd_uframe_slot.sv */
`timescale 1ns/1ps
`default_nettype none
module isd_uframe_slot
  import isd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  isd_slot_if.slot sb
);
  logic [7:0] count;
  logic [2:0] code;
  logic [7:0] next_count;
  logic [2:0] next_code;

  // clear wins over a result in the same cycle; it comes with any run write, even mid-transfer
  always_comb
  begin
    next_count = count;
    next_code = code;
    if (sb.clr)
    begin
      next_count = ISD_COUNT_RST;
      next_code = ISD_CODE_RST;
    end
    else if (sb.wr)
    begin
      next_code = sb.code_in;
      if (sb.wr_count)
        next_count = sb.count_in;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= ISD_COUNT_RST;
      code <= ISD_CODE_RST;
    end
    else
    begin
      count <= next_count;
      code <= next_code;
    end
  end

  assign sb.count = count;
  assign sb.code = code;
endmodule : isd_uframe_slot
`default_nettype wire

/* dv/isd_split_desc_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module isd_split_desc_asserts
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic uframe_tick,
  input wire logic [2:0] uframe_index,
  input wire logic split_issue,
  input wire logic [2:0] split_uframe,
  input wire logic result_valid
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  chk_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // a split waits for its result, so two issues never sit close together
  chk_issue_gap: assert property (split_issue |=> !split_issue [*2])
    else $error("splits issued too close");
  chk_issue_slot: assert property (split_issue |-> $past(uframe_tick)
    && split_uframe == $past(uframe_index)) else $error("split outside its microframe");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (split_issue);
  cover property (result_valid);
endmodule : isd_split_desc_asserts
bind isd_split_desc isd_split_desc_asserts i_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .uframe_tick,
  .uframe_index, .split_issue, .split_uframe, .result_valid);
`default_nettype wire

/* dv/isd_tt_model.sv */
`timescale 1ns/1ps
`default_nettype none
module isd_tt_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic split_issue,
  input wire logic split_is_complete,
  input wire logic [2:0] split_uframe,
  output logic uframe_tick,
  output logic [2:0] uframe_index,
  output logic [4:0] bus_frame,
  output logic result_valid,
  output logic [7:0] result_bytes,
  output logic [2:0] result_code
);
  logic [3:0] div;
  logic [3:0] wait_cnt;
  logic pend;
  logic [2:0] pend_uf;
  logic pend_cs;
  // microframe every 16 cycles; the frame steps as index wraps to 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div <= 4'h0;
      uframe_tick <= 1'b0;
      uframe_index <= 3'h7;
      bus_frame <= 5'h00;
      pend <= 1'b0;
      result_valid <= 1'b0;
    end
    else
    begin
      div <= div + 4'h1;
      uframe_tick <= (div == 4'hF);
      if (div == 4'hF)
        uframe_index <= uframe_index + 3'h1;
      if (div == 4'hF && uframe_index == 3'h7)
        bus_frame <= bus_frame + 5'h01;
      // idle result lines toggle so a stale value is never mistaken for data
      result_valid <= 1'b0;
      result_bytes <= ~result_bytes;
      result_code <= ~result_code;
      if (split_issue)
      begin
        pend <= 1'b1;
        pend_uf <= split_uframe;
        pend_cs <= split_is_complete;
        wait_cnt <= slow ? 4'hA : 4'h0;
      end
      else if (pend && wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
      else if (pend)
      begin
        pend <= 1'b0;
        result_valid <= 1'b1;
        // complete splits answer with bit 3 set, so the split kind shows in the counts
        result_bytes <= 8'hA0 | {4'h0, pend_cs, pend_uf};
        result_code <= 3'h7;
      end
    end
  end
endmodule : isd_tt_model
`default_nettype wire

/* dv/test_isd_split_desc.sv */
`timescale 1ns/1ps
`default_nettype none
module test_isd_split_desc
  import isd_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, result_bytes;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] uframe_index, split_uframe, result_code;
  logic [4:0] bus_frame, frame;
  logic uframe_tick, split_issue, split_is_complete, result_valid, slow;
  logic [3:0] seen[$];
  int fails, checks, cycles;
  isd_split_desc i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uframe_tick, .uframe_index, .bus_frame,
    .split_issue, .split_is_complete, .split_uframe, .result_valid, .result_bytes,
    .result_code);
  isd_tt_model i_tt (.aclk, .aresetn, .slow, .split_issue, .split_is_complete,
    .split_uframe, .uframe_tick, .uframe_index, .bus_frame, .result_valid, .result_bytes,
    .result_code);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] v, input logic [31:0] e);
    checks++;
    if (v !== e)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, v, e);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // hang guard, well above the longest run including a missed frame
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  // log every split; each must fall in the descriptor's frame
  always @(posedge aclk)
  begin
    if (split_issue === 1'b1)
    begin
      seen.push_back({split_is_complete, split_uframe});
      check(32'(bus_frame), 32'(frame));
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rdr(a, rd, rsp);
    check(rd, e);
    check(32'(rsp), 32'(ISD_RESP_OKAY));
  endtask : rd_chk
  // codes of value c for every microframe in mask m, uframe n at bit 8+3n
  function automatic logic [31:0] codes(input logic [7:0] m, input logic [2:0] c);
    codes = 32'h0;
    for (int n = 0; n < 8; n++)
      if (m[n])
        codes = codes | ({29'h0, c} << (8 + 3 * n));
  endfunction : codes
  // arm masks, start in the next bus frame, wait for done and clear it
  task automatic run_xfer(input logic in, input logic [7:0] ss, input logic [7:0] cs);
    wr(ISD_OFS_RESULT_WORD, {24'h0, ss}, rsp);
    check(32'(rsp), 32'(ISD_RESP_OKAY));
    wr(ISD_OFS_COUNT_LO, {24'h0, cs}, rsp);
    check(32'(rsp), 32'(ISD_RESP_OKAY));
    // start just after microframe 0, so the next frame is met from its first microframe
    do @(posedge aclk); while (!(uframe_tick === 1'b1 && uframe_index === 3'h0));
    frame = bus_frame + 5'h01;
    seen.delete();
    wr(ISD_OFS_CTRL, {25'h0, frame, in, 1'b1}, rsp);
    rd = 32'h0;
    for (int i = 0; i < 2000 && rd[1] !== 1'b1; i++)
      rdr(ISD_OFS_STAT, rd, rsp);
    check(rd, 32'h2);
    wr(ISD_OFS_STAT, 32'h2, rsp);
    rd_chk(ISD_OFS_STAT, 32'h0);
  endtask : run_xfer
  task automatic t_reset();
    for (int a = 0; a < 24; a += 4)
      rd_chk(8'(a), 32'h0);
    rdr(8'h18, rd, rsp);
    check(32'(rsp), 32'(ISD_RESP_SLVERR));
    check(rd, 32'h0);
    wr(8'h1C, 32'hFF, rsp);
    check(32'(rsp), 32'(ISD_RESP_SLVERR));
  endtask : t_reset
  // in: start split in uframe 0 only, completes in 2 and 4..7
  task automatic t_in();
    slow <= 1'b0;
    run_xfer(1'b1, 8'h01, 8'hF4);
    check(32'(seen.size()), 32'd6);
    foreach (seen[i])
      check(32'(seen[i]), 32'(i == 0 ? 4'h0 : 4'h8 + 4'(i == 1 ? 2 : i + 2)));
    rd_chk(ISD_OFS_RESULT_WORD, codes(8'hF5, 3'h3));
    // start split answers plain, complete splits with bit 3 set
    rd_chk(ISD_OFS_COUNT_LO, 32'hAA00A000);
    rd_chk(ISD_OFS_COUNT_MID, 32'hAEADAC00);
    rd_chk(ISD_OFS_COUNT_HI, 32'h000000AF);
  endtask : t_in
  // out with slow answers: complete mask ignored and kept, no counts stored
  task automatic t_out();
    slow <= 1'b1;
    run_xfer(1'b0, 8'h90, 8'h0F);
    check(32'(seen.size()), 32'd2);
    check(32'(seen[0]), 32'h4);
    check(32'(seen[1]), 32'h7);
    rd_chk(ISD_OFS_RESULT_WORD, codes(8'h90, 3'h5));
    rd_chk(ISD_OFS_COUNT_LO, 32'h0000000F);
    rd_chk(ISD_OFS_COUNT_MID, 32'h0);
    rd_chk(ISD_OFS_COUNT_HI, 32'h0);
  endtask : t_out
  initial
  begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    slow = 1'b0;
    frame = 5'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_in();
    t_out();
    tally_and_finish();
  end
endmodule : test_isd_split_desc
`default_nettype wire
